// ==== rtl/ise_core.sv ====
`timescale 1ns/1ps
// What this block does
// - Literal add into accumulator, updating carry, digit carry and zero.
// - Literal AND into accumulator, updating zero only.
// - Add accumulator and file register to chosen destination, all arithmetic flags.
// - Seven-bit file address; destination bit 0 accumulator, 1 file register.
// - AND accumulator with file register to chosen destination, zero only.
// - Return pops stack into program counter, two cycles, flags untouched.
// - Rotate file register right through carry, carry only.
// - Rotate file register left through carry, carry only.
// - Sleep clears watchdog, sets timeout, clears powerdown, enters sleep mode.
// - Swap file register nibbles to chosen destination, flags untouched.
// - Exclusive-OR in literal and file forms, zero only.
// - Direction load copies accumulator to port 5..7 direction register.
// - All but return take one word and one cycle.
module ise_core
  import ise_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic              op_valid,
  input  wire logic [OP_W-1:0]   opcode,
  input  wire logic [7:0]        file_rdata,
  input  wire logic [PC_W-1:0]   stack_top,
  output logic                   op_ready,
  output logic [FADDR_W-1:0]     file_addr,
  output logic [7:0]             file_wdata,
  output logic                   file_we,
  output logic [7:0]             working_accumulator,
  output logic                   carry_flag,
  output logic                   digit_carry_flag,
  output logic                   zero_flag,
  output logic                   timeout_flag,
  output logic                   powerdown_flag,
  output logic                   stack_pop,
  output logic                   pc_load,
  output logic [PC_W-1:0]        pc_value,
  output logic                   watchdog_clear,
  output logic                   sleep_mode,
  output logic [2:0]             dir_sel,
  output logic [7:0]             dir_wdata,
  output logic                   dir_we
);
  ////////////////////////////////////////////////////////////////////////////
  ise_dec_type   dec;
  logic [7:0]    alu_res;
  ise_flags_type alu_flg;
  logic [5:0]    hi6;
  logic          direction_load_op_hit;
  logic          fwd_hit;
  logic [7:0]    file_opnd;

  // Decode: upper six bits pick most operations; return and sleep match the whole word, direction load bits 13:3 plus a 5 to 7 selector
  always_comb begin
    hi6      = opcode[OP_W-1:OP_W-6];
    direction_load_op_hit = (opcode[OP_W-1:3] == OPW_DIRECTION_LOAD_OP) &&
               (opcode[2:0] >= DIRECTION_LOAD_OP_MIN) && (opcode[2:0] <= DIRECTION_LOAD_OP_MAX);
    dec         = '0;
    dec.op      = ISE_NOP;
    dec.to_file = opcode[DEST_BIT];
    if (hi6[5:1] == OPC_ADDLIT[5:1]) begin
      dec.op = ISE_ADD; dec.use_lit = 1'b1; dec.to_file = 1'b0;
      dec.set_cdc = 1'b1; dec.set_z = 1'b1;
    end else if (hi6 == OPC_ANDLIT) begin
      dec.op = ISE_AND; dec.use_lit = 1'b1; dec.to_file = 1'b0;
      dec.set_z = 1'b1;
    end else if (hi6 == OPC_XORLIT) begin
      dec.op = ISE_XOR; dec.use_lit = 1'b1; dec.to_file = 1'b0;
      dec.set_z = 1'b1;
    end else if (hi6 == OPC_ADDF) begin
      dec.op = ISE_ADD; dec.set_cdc = 1'b1; dec.set_z = 1'b1;
    end else if (hi6 == OPC_ANDF) begin
      dec.op = ISE_AND; dec.set_z = 1'b1;
    end else if (hi6 == OPC_XORF) begin
      dec.op = ISE_XOR; dec.set_z = 1'b1;
    end else if (hi6 == OPC_RRF) begin
      dec.op = ISE_RRF; dec.set_c = 1'b1;
    end else if (hi6 == OPC_RLF) begin
      dec.op = ISE_RLF; dec.set_c = 1'b1;
    end else if (hi6 == OPC_SWAP) begin
      dec.op = ISE_SWAP;
    end else if (opcode == OPW_RETURN) begin
      dec.op = ISE_RET; dec.to_file = 1'b0;
    end else if (opcode == OPW_SLEEP) begin
      dec.op = ISE_SLEEP; dec.to_file = 1'b0;
    end else if (direction_load_op_hit) begin
      dec.op = ISE_DIRECTION_LOAD_OP; dec.to_file = 1'b0;
    end else begin
      dec.to_file = 1'b0;
    end
  end

  // Forward a file write still in flight; the file only takes it next edge
  always_comb begin
    fwd_hit   = file_we && (file_addr == opcode[FADDR_W-1:0]);
    file_opnd = fwd_hit ? file_wdata : file_rdata;
  end

  ise_alu u_alu (
    .op   (dec.op),
    .a    (working_accumulator),
    .b    (dec.use_lit ? opcode[DATA_W-1:0] : file_opnd),
    .c_in (carry_flag),
    .res  (alu_res),
    .flg  (alu_flg)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencing: return holds a second cycle, all else single cycle
  typedef enum logic [0:0] {ISE_EXEC = 1'b0, ISE_RET2 = 1'b1} ise_state_type;
  ise_state_type state_r, state_nxt;
  logic          take;

  always_comb begin
    take      = op_valid && (state_r == ISE_EXEC) && !sleep_mode;
    state_nxt = state_r;
    unique case (state_r)
      ISE_EXEC: if (take && dec.op == ISE_RET) state_nxt = ISE_RET2;
      ISE_RET2: state_nxt = ISE_EXEC;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) state_r <= ISE_EXEC;
    else         state_r <= state_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Architectural state and one-cycle strobes
  logic [7:0]      w_nxt, fw_nxt, dw_nxt;
  logic            c_nxt, dc_nxt, z_nxt, to_nxt, pd_nxt, fwe_nxt, pop_nxt;
  logic            pcl_nxt, wdc_nxt, slp_nxt, dwe_nxt, rdy_nxt;
  logic [PC_W-1:0] pc_nxt;
  logic [2:0]      ds_nxt;
  logic [FADDR_W-1:0] fa_nxt;

  always_comb begin
    w_nxt = working_accumulator; c_nxt = carry_flag;
    dc_nxt = digit_carry_flag; z_nxt = zero_flag;
    to_nxt = timeout_flag; pd_nxt = powerdown_flag;
    fw_nxt = file_wdata; fa_nxt = opcode[FADDR_W-1:0];
    fwe_nxt = 1'b0; pop_nxt = 1'b0; pcl_nxt = 1'b0; pc_nxt = pc_value;
    wdc_nxt = 1'b0; slp_nxt = sleep_mode; dwe_nxt = 1'b0;
    ds_nxt = dir_sel; dw_nxt = dir_wdata;
    rdy_nxt = (state_nxt == ISE_EXEC) && !slp_nxt;
    if (take) begin
      unique case (dec.op)
        ISE_RET: begin
          pop_nxt = 1'b1; pcl_nxt = 1'b1; pc_nxt = stack_top;
        end
        ISE_SLEEP: begin
          wdc_nxt = 1'b1; to_nxt = 1'b1; pd_nxt = 1'b0;
          slp_nxt = 1'b1; rdy_nxt = 1'b0;
        end
        ISE_DIRECTION_LOAD_OP: begin
          dwe_nxt = 1'b1; ds_nxt = opcode[DIRECTION_LOAD_OP_SEL_W-1:0];
          dw_nxt = working_accumulator;
        end
        ISE_NOP: ;
        default: begin
          if (dec.to_file) begin
            fwe_nxt = 1'b1; fw_nxt = alu_res;
          end else begin
            w_nxt = alu_res;
          end
          if (dec.set_cdc) begin
            c_nxt = alu_flg.c; dc_nxt = alu_flg.dc;
          end
          if (dec.set_c) c_nxt = alu_flg.c;
          if (dec.set_z) z_nxt = alu_flg.z;
        end
      endcase
    end
  end

  // Sleep is left only by reset here; wake sources sit outside
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      working_accumulator <= ZERO_BYTE;
      carry_flag <= 1'b0; digit_carry_flag <= 1'b0; zero_flag <= 1'b0;
      timeout_flag <= 1'b1; powerdown_flag <= 1'b1;
      file_addr <= '0; file_wdata <= ZERO_BYTE; file_we <= 1'b0;
      stack_pop <= 1'b0; pc_load <= 1'b0; pc_value <= '0;
      watchdog_clear <= 1'b0; sleep_mode <= 1'b0;
      dir_sel <= '0; dir_wdata <= ZERO_BYTE; dir_we <= 1'b0;
      op_ready <= 1'b0;
    end else begin
      working_accumulator <= w_nxt;
      carry_flag <= c_nxt; digit_carry_flag <= dc_nxt; zero_flag <= z_nxt;
      timeout_flag <= to_nxt; powerdown_flag <= pd_nxt;
      file_addr <= fa_nxt; file_wdata <= fw_nxt; file_we <= fwe_nxt;
      stack_pop <= pop_nxt; pc_load <= pcl_nxt; pc_value <= pc_nxt;
      watchdog_clear <= wdc_nxt; sleep_mode <= slp_nxt;
      dir_sel <= ds_nxt; dir_wdata <= dw_nxt; dir_we <= dwe_nxt;
      op_ready <= rdy_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_ret_two_cyc: assert property (@(posedge clk) disable iff (!arst_n)
    (take && dec.op == ISE_RET) |=> (stack_pop && !op_ready) ##1 op_ready)
    else $error("return not two cycles");
  a_ret_flags: assert property (@(posedge clk) disable iff (!arst_n)
    (take && dec.op == ISE_RET) |=> $stable({carry_flag, digit_carry_flag, zero_flag}))
    else $error("return changed flags");
  a_sleep_eff: assert property (@(posedge clk) disable iff (!arst_n)
    (take && dec.op == ISE_SLEEP) |=> (timeout_flag && !powerdown_flag &&
     watchdog_clear && sleep_mode))
    else $error("sleep effects missing");
  a_lit_add: assert property (@(posedge clk) disable iff (!arst_n)
    (take && hi6[5:1] == OPC_ADDLIT[5:1]) |=>
     working_accumulator == 8'($past(working_accumulator) + $past(opcode[7:0])))
    else $error("literal add wrong");
  a_dest_file: assert property (@(posedge clk) disable iff (!arst_n)
    (take && dec.to_file && dec.op inside {ISE_ADD, ISE_AND, ISE_XOR}) |=>
     file_we && $stable(working_accumulator))
    else $error("file destination wrong");
  a_swap_flags: assert property (@(posedge clk) disable iff (!arst_n)
    (take && dec.op == ISE_SWAP) |=> $stable({carry_flag, zero_flag, digit_carry_flag}))
    else $error("swap touched flags");
  a_and_zonly: assert property (@(posedge clk) disable iff (!arst_n)
    (take && hi6 == OPC_ANDF) |=> $stable({carry_flag, digit_carry_flag}))
    else $error("and touched carry");
  a_rot_carry: assert property (@(posedge clk) disable iff (!arst_n)
    (take && dec.op == ISE_RRF) |=> carry_flag == $past(file_opnd[0]))
    else $error("rotate carry wrong");
  a_direction_load_op_load: assert property (@(posedge clk) disable iff (!arst_n)
    (take && dec.op == ISE_DIRECTION_LOAD_OP) |=> dir_we && dir_wdata == $past(working_accumulator))
    else $error("direction load wrong");
  a_one_cycle: assert property (@(posedge clk) disable iff (!arst_n)
    (take && !(dec.op inside {ISE_RET, ISE_SLEEP})) |=> op_ready)
    else $error("not single cycle");
endmodule

// ==== rtl/ise_pkg.sv ====
package ise_pkg;
  // Instruction word layout
  localparam int OP_W       = 14;
  localparam int DATA_W     = 8;
  localparam int FADDR_W    = 7;
  localparam int PC_W       = 13;
  localparam int DEST_BIT   = 7;
  localparam int NIB_W      = 4;
  localparam int DIRECTION_LOAD_OP_SEL_W = 3;

  // Upper six opcode bits
  localparam logic [5:0] OPC_ADDLIT = 6'h3E; // 11 111x, low bit ignored
  localparam logic [5:0] OPC_ANDLIT = 6'h39;
  localparam logic [5:0] OPC_XORLIT = 6'h3A;
  localparam logic [5:0] OPC_ADDF   = 6'h07;
  localparam logic [5:0] OPC_ANDF   = 6'h05;
  localparam logic [5:0] OPC_XORF   = 6'h06;
  localparam logic [5:0] OPC_RRF    = 6'h0C;
  localparam logic [5:0] OPC_RLF    = 6'h0D;
  localparam logic [5:0] OPC_SWAP   = 6'h0E;

  // Whole-word opcodes
  localparam logic [13:0] OPW_RETURN = 14'h0008;
  localparam logic [13:0] OPW_SLEEP  = 14'h0063;
  localparam logic [10:0] OPW_DIRECTION_LOAD_OP   = 11'h00C; // word[13:3]
  localparam logic [2:0]  DIRECTION_LOAD_OP_MIN   = 3'h5;
  localparam logic [2:0]  DIRECTION_LOAD_OP_MAX   = 3'h7;

  localparam logic [7:0]  ZERO_BYTE  = 8'h00;

  typedef enum logic [3:0] {
    ISE_NOP, ISE_ADD, ISE_AND, ISE_XOR, ISE_RRF, ISE_RLF, ISE_SWAP,
    ISE_RET, ISE_SLEEP, ISE_DIRECTION_LOAD_OP
  } ise_op_type;

  typedef struct packed {
    logic       c;
    logic       dc;
    logic       z;
  } ise_flags_type;

  typedef struct packed {
    ise_op_type       op;
    logic             use_lit;
    logic             to_file;
    logic             set_cdc;
    logic             set_z;
    logic             set_c;
  } ise_dec_type;
endpackage

// ==== rtl/ise_alu.sv ====
`timescale 1ns/1ps
module ise_alu
  import ise_pkg::*;
(
  input  wire ise_op_type    op,
  input  wire logic [7:0]    a,
  input  wire logic [7:0]    b,
  input  wire logic          c_in,
  output logic [7:0]         res,
  output ise_flags_type      flg
);
  logic [4:0] lo_sum;
  logic [8:0] full_sum;

  // A separate low-nibble add gives the nibble carry beside the full 8-bit add
  always_comb begin
    lo_sum   = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    full_sum = {1'b0, a} + {1'b0, b};
    res      = b;
    flg.c    = c_in;
    flg.dc   = lo_sum[NIB_W];
    unique case (op)
      ISE_ADD:  begin
        res   = full_sum[DATA_W-1:0];
        flg.c = full_sum[DATA_W];
      end
      ISE_AND:  res = a & b;
      ISE_XOR:  res = a ^ b;
      ISE_RRF:  begin
        res   = {c_in, b[DATA_W-1:1]};
        flg.c = b[0];
      end
      ISE_RLF:  begin
        res   = {b[DATA_W-2:0], c_in};
        flg.c = b[DATA_W-1];
      end
      ISE_SWAP: res = {b[NIB_W-1:0], b[DATA_W-1:NIB_W]};
      default:  res = b;
    endcase
    flg.z = (res == ZERO_BYTE);
  end
endmodule

// ==== bench/ise_partner.sv ====
`timescale 1ns/1ps
// Data register file and return stack beside the execute block
module ise_partner
  import ise_pkg::*;
(
  input  wire logic               clk,
  input  wire logic [FADDR_W-1:0] rd_addr,
  output logic [7:0]              rdata,
  input  wire logic               we,
  input  wire logic [FADDR_W-1:0] waddr,
  input  wire logic [7:0]         wdata,
  input  wire logic               pop,
  output logic [PC_W-1:0]         top
);
  logic [7:0] mem [128];
  logic [1:0] sp;
  ////////////////////////////////////////////////////////////////
  // Distinct preset bytes so a wrong address shows up at once
  initial begin
    sp = 2'h0;
    for (int i = 0; i < 128; i++) begin
      mem[i] = 8'(i * 29 + 60);
    end
  end
  // Same-cycle read; the stack top moves with every pop
  assign rdata = mem[rd_addr];
  assign top   = {11'h2B5, sp};
  // Writes and pops land on the edge that the block drives them for
  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    if (pop) begin
      sp <= sp + 2'h1;
    end
  end
endmodule

// ==== bench/instr_subset_execute_test.sv ====
`timescale 1ns/1ps
module instr_subset_execute_test
  import ise_pkg::*;
;
  logic               clk = 1'b0;
  logic               arst_n = 1'b0;
  logic               op_valid = 1'b0;
  logic [OP_W-1:0]    opcode = 14'h0000;
  logic [7:0]         file_rdata, file_wdata, working_accumulator, dir_wdata, w;
  logic [PC_W-1:0]    stack_top, pc_value;
  logic [FADDR_W-1:0] file_addr;
  logic [2:0]         dir_sel;
  logic               op_ready, file_we, carry_flag, digit_carry_flag, zero_flag, c;
  logic               timeout_flag, powerdown_flag, stack_pop, pc_load, dc, z;
  logic               watchdog_clear, sleep_mode, dir_we;
  logic [7:0]         fm [128];
  int                 n_mismatch = 0;
  int                 tests_run = 0;
  // Boundary addresses, both destinations, carry and zero corners
  localparam logic [13:0] OPS [17] = '{{OPC_ADDLIT, 8'hFF}, {6'h3F, 8'h01},
    {OPC_XORLIT, 8'hA5}, {OPC_ANDLIT, 8'h0F}, {OPC_ADDF, 8'hFF}, {OPC_ADDF, 8'h00},
    {OPC_ANDF, 8'h10}, {OPC_XORF, 8'h91}, {OPC_XORF, 8'h11}, {OPC_RRF, 8'h21},
    {OPC_RLF, 8'hA2}, {OPC_SWAP, 8'h33}, {OPC_SWAP, 8'hB4}, {OPC_RRF, 8'hC0},
    {OPC_RLF, 8'h41}, {OPC_ANDF, 8'h85}, {OPC_ADDF, 8'hFE}};
  always #2.5 clk = ~clk;
  ////////////////////////////////////////////////////////////////
  ise_core i_dut (.clk, .arst_n, .op_valid, .opcode, .file_rdata, .stack_top, .op_ready,
    .file_addr, .file_wdata, .file_we, .working_accumulator, .carry_flag, .digit_carry_flag,
    .zero_flag, .timeout_flag, .powerdown_flag, .stack_pop, .pc_load, .pc_value,
    .watchdog_clear, .sleep_mode, .dir_sel, .dir_wdata, .dir_we);
  ise_partner i_part (.clk, .rd_addr(opcode[6:0]), .rdata(file_rdata), .we(file_we),
    .waddr(file_addr), .wdata(file_wdata), .pop(stack_pop), .top(stack_top));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Reset values, then release on a falling edge
  task automatic do_reset();
    arst_n = 1'b0;
    op_valid = 1'b0;
    repeat (8) @(negedge clk);
    chk(16'({timeout_flag, powerdown_flag, working_accumulator, carry_flag, digit_carry_flag,
      zero_flag, sleep_mode, op_ready}), 16'({2'b11, 13'h0000}));
    arst_n = 1'b1;
    {w, c, dc, z} = 11'h000;
    repeat (2) @(negedge clk);
  endtask
  // One arithmetic or logic op, predicted here and judged a cycle later
  task automatic alu_op(input logic [13:0] op);
    logic [7:0] a, r;
    logic [8:0] s;
    logic [4:0] h;
    logic       lit, d;
    logic [5:0] u;
    u = op[13:8];
    lit = (u[5:4] == 2'b11);
    d = op[DEST_BIT] & ~lit;
    a = lit ? op[7:0] : fm[op[6:0]];
    s = {1'b0, w} + {1'b0, a};
    h = {1'b0, w[3:0]} + {1'b0, a[3:0]};
    r = {a[3:0], a[7:4]};
    if (u == OPC_ANDLIT || u == OPC_ANDF) r = w & a;
    if (u == OPC_XORLIT || u == OPC_XORF) r = w ^ a;
    if (u == OPC_RRF) {r, c} = {c, a};
    if (u == OPC_RLF) {c, r} = {a, c};
    if (u[5:1] == OPC_ADDLIT[5:1] || u == OPC_ADDF) {dc, c, r} = {h[4], s};
    if (u != OPC_RRF && u != OPC_RLF && u != OPC_SWAP) z = (r == ZERO_BYTE);
    opcode = op;
    op_valid = 1'b1;
    @(negedge clk);
    chk(16'(file_we), 16'(d));
    if (d) begin
      chk(16'({file_addr, file_wdata}), 16'({op[6:0], r}));
      fm[op[6:0]] = r;
    end else begin
      w = r;
    end
    chk(16'({working_accumulator, carry_flag, digit_carry_flag, zero_flag, op_ready}),
      16'({w, c, dc, z, 1'b1}));
  endtask
  // Return, with an op offered in its dead cycle that must be dropped
  task automatic ret_op();
    logic [PC_W-1:0] t;
    t = stack_top;
    opcode = OPW_RETURN;
    op_valid = 1'b1;
    @(negedge clk);
    chk(16'({stack_pop, pc_load, pc_value, op_ready}), 16'({2'b11, t, 1'b0}));
    opcode = {OPC_ADDLIT, 8'h01};
    @(negedge clk);
    chk(16'({working_accumulator, carry_flag, digit_carry_flag, zero_flag, op_ready,
      stack_pop}), 16'({w, c, dc, z, 2'b10}));
  endtask
  // Port selectors; only 5 to 7 may load, and 3 is the sleep code
  task automatic dir_load();
    for (int s = 0; s < 8; s++) begin
      if (3'(s) == OPW_SLEEP[2:0]) continue;
      opcode = {OPW_DIRECTION_LOAD_OP, 3'(s)};
      op_valid = 1'b1;
      @(negedge clk);
      chk(16'(dir_we), 16'(s >= 5));
      if (s >= 5) chk(16'({dir_sel, dir_wdata, carry_flag, digit_carry_flag, zero_flag}),
        16'({3'(s), w, c, dc, z}));
    end
  endtask
  // Sleep, then an op that must be ignored while asleep
  task automatic sleep_op();
    opcode = OPW_SLEEP;
    op_valid = 1'b1;
    @(negedge clk);
    chk(16'({watchdog_clear, timeout_flag, powerdown_flag, sleep_mode, op_ready}),
      16'(5'b11010));
    opcode = {OPC_ADDLIT, 8'h01};
    @(negedge clk);
    chk(16'({working_accumulator, watchdog_clear, sleep_mode}), 16'({w, 2'b01}));
  endtask
  ////////////////////////////////////////////////////////////////
  // Hang guard far above the few dozen cycles the run needs
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    close_out();
  end
  // Main sequence; ops follow each other with no gap where allowed
  initial begin
    for (int i = 0; i < 128; i++) fm[i] = 8'(i * 29 + 60);
    do_reset();
    foreach (OPS[i]) alu_op(OPS[i]);
    ret_op();
    alu_op({OPC_ADDF, 8'h8F});
    alu_op({OPC_XORF, 8'h0F});
    dir_load();
    ret_op();
    sleep_op();
    do_reset();
    alu_op({OPC_ADDLIT, 8'h80});
    op_valid = 1'b0;
    @(negedge clk);
    close_out();
  end
endmodule
